// >>> src/rss_regs.svh
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RSS_PSF_ADDR 8'h86
`define RSS_IRQ_STAT_ADDR 8'h90
`define RSS_IRQ_MASK_ADDR 8'h91

// ****************************************
// Field positions
// ****************************************
`define RSS_CAUSE_HI_BIT 7
`define RSS_CAUSE_LO_BIT 6
`define RSS_MID_FLAG_BIT 5
`define RSS_LOW_FLAG_BIT 4
`define RSS_ALU_MSB 2
`define RSS_IRQ_WDT_BIT 0
`define RSS_IRQ_SUPPLY_BIT 1
`define RSS_IRQ_EXT_BIT 2
`define RSS_IRQ_BOOT_BIT 3
`define RSS_IRQ_MSB 3

// ****************************************
// Reset values and codes
// ****************************************
`define RSS_CAUSE_WDT 2'h0
`define RSS_CAUSE_RSVD 2'h1
`define RSS_CAUSE_POR 2'h2
`define RSS_CAUSE_EXT 2'h3
`define RSS_ALU_RESET 3'h0
`define RSS_IRQ_RESET 4'h0
`define RSS_RESET_VECTOR 12'h000

// ****************************************
// Timing
// ****************************************
`define RSS_CLK_PERIOD_NS 25
`define RSS_PWR_STABLE_NS 1000
`define RSS_RC_WARM_NS 500
`define RSS_XTAL_WARM_NS 50000
`define RSS_NS_TO_CYC(t) (((t) + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_PWR_STABLE_CYC `RSS_NS_TO_CYC(`RSS_PWR_STABLE_NS)
`define RSS_RC_WARM_CYC `RSS_NS_TO_CYC(`RSS_RC_WARM_NS)
`define RSS_XTAL_WARM_CYC `RSS_NS_TO_CYC(`RSS_XTAL_WARM_NS)

`endif

// >>> src/rss_pkg.sv
// ****************************************
// Shared types
// ****************************************
package rss_pkg;

   typedef enum logic [2:0] {
      S_POWER,
      S_EXT_CHECK,
      S_INIT,
      S_WARM,
      S_RUN
   } rss_state_t;

   // Levels arriving from outside the core clock domain
   typedef struct packed {
      logic supply_ok;
      logic brownout;
      logic ext_pin;
      logic osc_ready;
      logic low_det;
      logic mid_det;
      logic ext_en;
      logic xtal_sel;
   } rss_pins_t;

endpackage

// >>> src/rss_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"

module rss_reset_sequencer
   import rss_pkg::*;
#(
   parameter int unsigned PWR_CYC = `RSS_PWR_STABLE_CYC,
   parameter int unsigned RC_CYC = `RSS_RC_WARM_CYC,
   parameter int unsigned XTAL_CYC = `RSS_XTAL_WARM_CYC
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic wdt_overflow,
   input wire rss_pins_t pins_async,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic core_reset_n,
   output logic core_clk_en,
   output logic pc_clear,
   output logic sys_init,
   output logic [11:0] start_addr,
   output logic irq
);

   // ****************************************
   // Reset and input synchronisers
   // ****************************************
   logic rst_s1;
   logic rst_n;
   rss_pins_t pins_s1;
   rss_pins_t pins;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Supply and pin levels idle at their safe value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_s1 <= '0;
         pins <= '0;
      end else begin
         pins_s1 <= pins_async;
         pins <= pins_s1;
      end
   end

   function automatic logic cyc_done(input logic [15:0] cnt,
                                     input int unsigned len);
      cyc_done = (cnt >= 16'(len - 1));
   endfunction

   // ****************************************
   // Reset events
   // ****************************************
   logic ev_supply;
   logic ev_ext;
   logic ev_wdt;
   logic restart;
   rss_state_t state;
   rss_state_t next_state;
   logic [1:0] next_cause;
   logic [1:0] cause;
   logic [15:0] cnt;
   logic warm_long;

   assign ev_supply = !pins.supply_ok || pins.brownout;
   assign ev_ext = pins.ext_en && !pins.ext_pin;
   assign ev_wdt = wdt_overflow;
   assign warm_long = pins.xtal_sel;

   // ****************************************
   // Sequence
   // ****************************************
   always_comb begin
      next_state = state;
      next_cause = cause;
      restart = 1'b0;
      if (ev_supply) begin
         next_state = S_POWER;
         next_cause = `RSS_CAUSE_POR;
         restart = 1'b1;
      end else if (ev_ext && state != S_POWER
                   && state != S_EXT_CHECK) begin
         next_state = S_EXT_CHECK;
         next_cause = `RSS_CAUSE_EXT;
         restart = 1'b1;
      end else if (ev_wdt && state == S_RUN) begin
         next_state = S_INIT;
         next_cause = `RSS_CAUSE_WDT;
         restart = 1'b1;
      end else begin
         case (state)
            S_POWER: begin
               if (cyc_done(cnt, PWR_CYC)) begin
                  next_state = S_EXT_CHECK;
               end
            end
            S_EXT_CHECK: begin
               if (!ev_ext) begin
                  next_state = S_INIT;
               end
            end
            S_INIT: begin
               next_state = S_WARM;
            end
            S_WARM: begin
               // Oscillator must both have run its time and report ready
               if (pins.osc_ready
                   && cyc_done(cnt, warm_long ? XTAL_CYC : RC_CYC)) begin
                  next_state = S_RUN;
               end
            end
            S_RUN: begin
               next_state = S_RUN;
            end
            default: begin
               next_state = S_POWER;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_POWER;
      end else begin
         state <= next_state;
      end
   end

   // Counter restarts on every state change and every event that raises restart
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 16'h0000;
      end else if (restart || next_state != state) begin
         cnt <= 16'h0000;
      end else if (!(&cnt)) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // ****************************************
   // Core controls
   // ****************************************
   assign core_reset_n = (state == S_RUN);
   assign core_clk_en = (state == S_RUN);
   assign pc_clear = (state != S_RUN);
   assign sys_init = (state == S_INIT);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_addr <= `RSS_RESET_VECTOR;
      end else if (state != S_RUN) begin
         start_addr <= `RSS_RESET_VECTOR;
      end
   end

   // ****************************************
   // Status flag register
   // ****************************************
   logic psf_wr;
   logic low_flag;
   logic mid_flag;
   logic [`RSS_ALU_MSB:0] alu_flags;

   assign psf_wr = reg_wr && reg_addr == `RSS_PSF_ADDR;

   // Software may rewrite the cause, but the reserved code is refused
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause <= `RSS_CAUSE_POR;
      end else if (restart) begin
         cause <= next_cause;
      end else if (psf_wr && reg_wdata[7:6] != `RSS_CAUSE_RSVD) begin
         cause <= reg_wdata[7:6];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_flag <= 1'b0;
         mid_flag <= 1'b0;
      end else if (ev_supply) begin
         low_flag <= 1'b0;
         mid_flag <= 1'b0;
      end else if (state == S_RUN) begin
         low_flag <= pins.low_det;
         mid_flag <= pins.mid_det;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alu_flags <= `RSS_ALU_RESET;
      end else if (sys_init) begin
         alu_flags <= `RSS_ALU_RESET;
      end else if (psf_wr) begin
         alu_flags <= reg_wdata[`RSS_ALU_MSB:0];
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   logic [`RSS_IRQ_MSB:0] irq_stat;
   logic [`RSS_IRQ_MSB:0] irq_mask;
   logic [`RSS_IRQ_MSB:0] irq_set;
   logic [`RSS_IRQ_MSB:0] irq_clr;

   always_comb begin
      irq_set = '0;
      irq_set[`RSS_IRQ_WDT_BIT] = restart
         && next_cause == `RSS_CAUSE_WDT;
      irq_set[`RSS_IRQ_SUPPLY_BIT] = restart
         && next_cause == `RSS_CAUSE_POR;
      irq_set[`RSS_IRQ_EXT_BIT] = restart
         && next_cause == `RSS_CAUSE_EXT;
      irq_set[`RSS_IRQ_BOOT_BIT] = next_state == S_RUN
         && state != S_RUN;
      irq_clr = '0;
      if (reg_wr && reg_addr == `RSS_IRQ_STAT_ADDR) begin
         irq_clr = reg_wdata[`RSS_IRQ_MSB:0];
      end
   end

   // A new event in the clearing cycle is kept
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= `RSS_IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= `RSS_IRQ_RESET;
      end else if (reg_wr && reg_addr == `RSS_IRQ_MASK_ADDR) begin
         irq_mask <= reg_wdata[`RSS_IRQ_MSB:0];
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `RSS_PSF_ADDR: begin
               reg_rdata <= {cause, mid_flag, low_flag, 1'b0,
                             alu_flags};
            end
            `RSS_IRQ_STAT_ADDR: begin
               reg_rdata <= {4'h0, irq_stat};
            end
            `RSS_IRQ_MASK_ADDR: begin
               reg_rdata <= {4'h0, irq_mask};
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   supply_reset_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ev_supply |=> !core_reset_n && state == S_POWER)
      else $error("supply event did not reset the core");

   halt_pc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      restart |=> !core_reset_n && pc_clear && !core_clk_en)
      else $error("core not halted during reset");

   boot_vector_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(core_reset_n) |-> start_addr == 12'h000)
      else $error("boot address not zero");

   cause_rsvd_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cause != 2'h1)
      else $error("reserved cause code produced");

   ext_cause_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == S_RUN && ev_ext && !ev_supply)
         |=> cause == 2'h3 && state == S_EXT_CHECK)
      else $error("external reset cause not recorded");

   run_order_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(core_reset_n) |-> $past(state) == S_WARM)
      else $error("run entered without warm-up");

   pin_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == S_EXT_CHECK && ev_ext) |=> state inside {S_EXT_CHECK, S_POWER})
      else $error("released while external pin low");

   wdt_path_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == S_RUN && ev_wdt && !ev_supply && !ev_ext)
         |=> state == S_INIT && cause == 2'h0
         ##1 (state == S_WARM || $past(ev_supply || ev_ext)))
      else $error("watchdog path wrong");

   clk_osc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(core_clk_en) |-> $past(pins.osc_ready))
      else $error("clock released before oscillator ready");

   warm_len_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state == S_WARM && next_state == S_RUN)
         |-> cnt >= 16'(($past(pins.xtal_sel) || pins.xtal_sel
                         ? XTAL_CYC : RC_CYC) - 1)
         || cnt >= 16'(RC_CYC - 1) && !pins.xtal_sel)
      else $error("warm-up too short");

   supply_flag_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ev_supply |=> !low_flag && !mid_flag)
      else $error("supply flags not cleared");

   irq_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      |irq_set |=> |irq_stat)
      else $error("event lost from interrupt status");

endmodule

`default_nettype wire

// >>> bench/rss_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Supply monitor, watchdog and reset pin
// ****
module rss_partner_model
   import rss_pkg::*;
#(
   parameter int unsigned OSC_DLY = 2
) (
   input wire logic core_clk,
   input wire logic supply_on,
   input wire logic brownout_on,
   input wire logic pin_low,
   input wire logic ext_en,
   input wire logic xtal,
   input wire logic [1:0] det,
   input wire logic wdt_kick,
   output var rss_pins_t pins,
   output logic wdt_overflow
);
   int unsigned osc_cnt = 0;
   logic kick_q = 1'b0;
   // Oscillator settles only after the supply has stayed up for a while
   always @(posedge core_clk) begin
      if (!supply_on)
         osc_cnt <= 0;
      else if (osc_cnt < OSC_DLY)
         osc_cnt <= osc_cnt + 1;
      kick_q <= wdt_kick;
   end
   // A held request still gives one overflow pulse only
   assign wdt_overflow = wdt_kick & !kick_q;
   always_comb begin
      pins.supply_ok = supply_on;
      pins.brownout = brownout_on;
      pins.ext_pin = !pin_low;
      pins.osc_ready = supply_on && (osc_cnt >= OSC_DLY);
      pins.low_det = det[0];
      pins.mid_det = det[1];
      pins.ext_en = ext_en;
      pins.xtal_sel = xtal;
   end
endmodule
`default_nettype wire

// >>> bench/rss_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
   miscompares++; $display("BAD %0t mismatch", $time); end end

module rss_reset_sequencer_test;
   import rss_pkg::*;
   localparam int unsigned PWR = 4;
   localparam int unsigned RC = 3;
   localparam int unsigned XT = 6;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wdt_overflow;
   rss_pins_t pins_async;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [7:0] d;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic core_reset_n, core_clk_en, pc_clear, sys_init, irq;
   logic [11:0] start_addr;
   logic sup = 1'b0, brownout = 1'b0, pin_low = 1'b0;
   logic ext_en = 1'b0, xtal = 1'b0, kick = 1'b0;
   logic [1:0] det = 2'h0;
   int miscompares = 0, cmp_count = 0;
   int n, inits, por_len, wdt_len;

   rss_partner_model far (.core_clk(core_clk), .supply_on(sup),
      .brownout_on(brownout), .pin_low(pin_low), .ext_en(ext_en),
      .xtal(xtal), .det(det), .wdt_kick(kick), .pins(pins_async),
      .wdt_overflow(wdt_overflow));

   rss_reset_sequencer #(.PWR_CYC(PWR), .RC_CYC(RC), .XTAL_CYC(XT)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .wdt_overflow(wdt_overflow),
      .pins_async(pins_async), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_reset_n(core_reset_n), .core_clk_en(core_clk_en),
      .pc_clear(pc_clear), .sys_init(sys_init), .start_addr(start_addr),
      .irq(irq));

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   // ****
   // Shared tasks
   // ****
   task automatic stop_test();
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Counts cycles in n and init pulses in inits
   task automatic wait_lvl(input logic v);
      n = 0;
      while (core_reset_n !== v) begin
         @(posedge core_clk);
         #1 n++;
         inits += (sys_init === 1'b1);
         if (n > 5000) begin
            $display("BAD %0t timeout", $time);
            miscompares++;
            stop_test();
         end
      end
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_por();
      inits = 0;
      repeat (3) @(posedge core_clk);
      sup <= 1'b1;
      #1 `CHK({core_reset_n, pc_clear}, 2'b01)
      wait_lvl(1'b1);
      por_len = n;
      `CHK(n > PWR + RC, 1'b1)
      `CHK(inits, 1)
      `CHK({core_clk_en, pc_clear}, 2'b10)
      `CHK(start_addr, `RSS_RESET_VECTOR)
      rd(`RSS_PSF_ADDR);
      `CHK(d[7:6], `RSS_CAUSE_POR)
      rd(`RSS_IRQ_STAT_ADDR);
      `CHK(d[`RSS_IRQ_BOOT_BIT], 1'b1)
      `CHK(d, 8'h0a)
      `CHK(irq, 1'b0)
      wr(`RSS_IRQ_MASK_ADDR, 8'h0f);
      @(posedge core_clk);
      #1 `CHK(irq, 1'b1)
      wr(`RSS_IRQ_STAT_ADDR, 8'h0f);
      @(posedge core_clk);
      #1 `CHK(irq, 1'b0)
   endtask

   task automatic t_regs();
      // Code 01 must not land; the low three bits are plain storage
      wr(`RSS_PSF_ADDR, 8'h45);
      rd(`RSS_PSF_ADDR);
      `CHK(d, 8'h85)
      wr(`RSS_PSF_ADDR, 8'hff);
      rd(`RSS_PSF_ADDR);
      `CHK(d, 8'hc7)
      rd(8'h00);
      `CHK(d, 8'h00)
      @(posedge core_clk);
      #1 `CHK(reg_rdata, 8'h00)
   endtask

   task automatic t_wdt();
      inits = 0;
      @(posedge core_clk);
      kick <= 1'b1;
      wait_lvl(1'b0);
      @(posedge core_clk);
      kick <= 1'b0;
      #1 `CHK(pc_clear, 1'b1)
      wait_lvl(1'b1);
      wdt_len = n;
      `CHK(n < por_len, 1'b1)
      `CHK(inits, 1)
      rd(`RSS_PSF_ADDR);
      `CHK(d, 8'h00)
      `CHK(irq, 1'b1)
      rd(`RSS_IRQ_STAT_ADDR);
      `CHK(d, 8'h09)
      wr(`RSS_IRQ_STAT_ADDR, 8'h0f);
   endtask

   task automatic t_ext();
      inits = 0;
      ext_en <= 1'b1;
      pin_low <= 1'b1;
      wait_lvl(1'b0);
      repeat (40) @(posedge core_clk);
      pin_low <= 1'b0;
      #1 `CHK(core_reset_n, 1'b0)
      wait_lvl(1'b1);
      `CHK(inits, 1)
      rd(`RSS_PSF_ADDR);
      `CHK(d[7:6], `RSS_CAUSE_EXT)
      rd(`RSS_IRQ_STAT_ADDR);
      `CHK(d, 8'h0c)
      wr(`RSS_IRQ_STAT_ADDR, 8'h0f);
   endtask

   task automatic t_brownout();
      // Distinct levels on the two detectors show which flag is which
      det <= 2'h1;
      repeat (4) @(posedge core_clk);
      rd(`RSS_PSF_ADDR);
      `CHK(d[5:4], 2'b01)
      @(posedge core_clk);
      brownout <= 1'b1;
      wait_lvl(1'b0);
      rd(`RSS_PSF_ADDR);
      `CHK(d[5:4], 2'b00)
      `CHK(d[7:6], `RSS_CAUSE_POR)
      @(posedge core_clk);
      brownout <= 1'b0;
      det <= 2'h0;
      wait_lvl(1'b1);
   endtask

   task automatic t_xtal();
      // Pin ignored while its function is off
      @(posedge core_clk);
      ext_en <= 1'b0;
      pin_low <= 1'b1;
      repeat (10) @(posedge core_clk);
      pin_low <= 1'b0;
      xtal <= 1'b1;
      #1 `CHK(core_reset_n, 1'b1)
      repeat (3) @(posedge core_clk);
      kick <= 1'b1;
      wait_lvl(1'b0);
      @(posedge core_clk);
      kick <= 1'b0;
      wait_lvl(1'b1);
      `CHK(n >= XT, 1'b1)
      `CHK(n > wdt_len, 1'b1)
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      t_por();
      t_regs();
      t_wdt();
      t_ext();
      t_brownout();
      t_xtal();
      stop_test();
   end
endmodule
`default_nettype wire
